// *** core/ntbw_ahb_if.v ***
// AHB-Lite slave front end: one wait state, registered read data.
// Assumes hready is this slave's own hreadyout; only word transfers act.
`timescale 1ns/1ns
`default_nettype none
`include "ntbw_defs.vh"
module ntbw_ahb_if
(
   input wire clk,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] rd_data,
   output wire acc,
   output wire acc_wr,
   output wire [`NTBW_AMSB:0] acc_addr,
   output reg [31:0] hrdata_r,
   output reg hreadyout_r
);
   reg pend_r;
   reg wr_r;
   reg word_r;
   reg [`NTBW_AMSB:0] addr_r;
   wire take;
   assign take = hsel && htrans[1] && hready;
   assign acc = pend_r && word_r;
   assign acc_wr = acc && wr_r;
   assign acc_addr = addr_r;
   // The wait state lets read data leave straight from a flop.
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pend_r <= 1'b0;
         wr_r <= 1'b0;
         word_r <= 1'b0;
         addr_r <= {(`NTBW_AMSB + 1){1'b0}};
         hrdata_r <= `NTBW_RST_WORD;
         hreadyout_r <= 1'b1;
      end
      else if (pend_r)
      begin
         pend_r <= 1'b0;
         hreadyout_r <= 1'b1;
         hrdata_r <= (word_r && !wr_r) ? rd_data : `NTBW_RST_WORD;
      end
      else if (take)
      begin
         pend_r <= 1'b1;
         hreadyout_r <= 1'b0;
         wr_r <= hwrite;
         word_r <= (hsize == `NTBW_HSIZE_WORD);
         addr_r <= {haddr[`NTBW_AMSB:2], 2'b00};
      end
   end
endmodule // ntbw_ahb_if
`default_nettype wire

// *** core/ntbw_bar_mask.v ***
// Writable-bit mask of one 32-bit slice of a window base address.
// Assumes size and mode come from flops on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "ntbw_defs.vh"
module ntbw_bar_mask
(
   input wire [5:0] size,
   input wire upper,
   input wire wide,
   output wire [31:0] mask
);
   wire small_size;
   // A size below the smallest window leaves nothing writable, which disables it.
   assign small_size = (size != 6'h00) && (size < `NTBW_SIZE_MIN);
   genvar j;
   generate
      for (j = 0; j < 32; j = j + 1)
      begin : g_bit
         localparam [6:0] POS = j;
         wire [6:0] a;
         assign a = upper ? (7'd32 + POS) : POS;
         assign mask[j] = (a >= 7'd4) && !small_size && (!upper || wide)
            && ((size == 6'h00) || (a >= {1'b0, size}));
      end
   endgenerate
endmodule // ntbw_bar_mask
`default_nettype wire

// *** core/ntbw_defs.vh ***
// Constants for the bridge window setup register bank.
// Assumes a 32-bit word bus; offsets are byte addresses.
`ifndef NTBW_DEFS_VH
`define NTBW_DEFS_VH
`define NTBW_OFS_W0_BAR 12'h010
`define NTBW_OFS_W1_BAR 12'h014
`define NTBW_OFS_W0_SETUP 12'h07C
`define NTBW_OFS_W0_XBASE 12'h080
`define NTBW_OFS_W1_SETUP 12'h084
`define NTBW_OFS_W0_XUPPER 12'h088
`define NTBW_AMSB 11
`define NTBW_F_SPACE 0
`define NTBW_F_TYPE_HI 2
`define NTBW_F_TYPE_LO 1
`define NTBW_F_FETCH 3
`define NTBW_F_SIZE_HI 9
`define NTBW_F_SIZE_LO 4
`define NTBW_F_EN 31
`define NTBW_F_XBASE_LO 4
`define NTBW_TYPE_ADDR32 2'h0
`define NTBW_TYPE_ADDR64 2'h2
`define NTBW_SIZE_MIN 6'h04
`define NTBW_UPPER_ADDR 6'h20
`define NTBW_RST_SETUP 32'h00000000
`define NTBW_RST_XBASE 28'h0000000
`define NTBW_RST_WORD 32'h00000000
`define NTBW_HTRANS_NONSEQ 2'h2
`define NTBW_HSIZE_WORD 3'h2
`define NTBW_HRESP_OKAY 1'h0
`endif

// *** core/ntbw_regs.v ***
// Window setup and translation registers of a non-transparent bridge.
// Assumes one AHB-Lite master on REF_CLK; COLD_RST is the power-on reset,
// SYS_RST stands for fundamental and hot reset.
//
// Overview of operation
// - With window 0's enable bit low the window is off and its base register reads zero.
// - Setup and translation fields survive fundamental and hot reset.
// - Bits 31:4 of the first translation register hold window 0's translated base.
// - In 64-bit mode the translated base also takes the upper translation register.
// - A 64-bit memory window 0 turns window 1 into the upper half of its base.
// - While so paired, window 1's setup register is read-only zero.
// - Bit 0 of window 1's setup picks memory or I/O space as its base reports.
// - Window 1's type field allows only 32-bit decoding; other codes are reserved.
// - In I/O space the type field is forced to zero whatever is written.
// - Bit 3 of window 1's setup is reported as its prefetchable bit.
// - Only the type field enables 64-bit decoding; in 32-bit mode a size beyond 32 bits leaves no base bit writable.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "ntbw_defs.vh"
module ntbw_regs
(
   input wire REF_CLK,
   input wire SYS_RST,
   input wire COLD_RST,
   input wire HSEL,
   input wire [31:0] HADDR,
   input wire [1:0] HTRANS,
   input wire HWRITE,
   input wire [2:0] HSIZE,
   input wire [31:0] HWDATA,
   input wire HREADY,
   output wire [31:0] HRDATA,
   output wire HREADYOUT,
   output reg HRESP,
   output reg WIN0_ENABLE,
   output reg WIN0_WIDE,
   output reg [63:0] WIN0_XLAT_BASE,
   output reg [63:0] WIN0_BASE,
   output reg WIN1_ENABLE,
   output reg [31:0] WIN1_BASE
);
   // Setup fields, indexed by window.
   reg en_r [0:1];
   reg space_r [0:1];
   reg [1:0] type_r [0:1];
   reg fetch_r [0:1];
   reg [5:0] size_r [0:1];
   reg [31:4] xbase_r;
   reg [31:0] xupper_r;
   // Base address registers, reset with the bus.
   reg [31:0] bar0_r;
   reg [31:0] bar1_r;
   reg [31:0] rd_nxt;
   wire acc;
   wire acc_wr;
   wire [`NTBW_AMSB:0] acc_addr;
   reg wide;
   wire [31:0] mask [0:2];
   wire [5:0] msize [0:2];
   wire mupper [0:2];
   reg [31:0] bar0_rd;
   reg [31:0] bar1_rd;
   wire [31:0] setup0_rd;
   reg [31:0] setup1_rd;
   reg [1:0] new_type0;
   wire [1:0] new_type1;
   reg [31:0] xlat_hi;
   reg [31:0] base_hi;

   // Full-word compare; the bus front end has already cleared the two low address bits.
   function hit;
      input [`NTBW_AMSB:0] addr;
      input [`NTBW_AMSB:0] ofs;
      begin
         hit = (addr == ofs);
      end
   endfunction

   // One packing serves both setup registers, so their layouts cannot drift apart.
   function [31:0] setup_word;
      input en;
      input [5:0] size;
      input fetch;
      input [1:0] typ;
      input space;
      begin
         setup_word = `NTBW_RST_SETUP;
         setup_word[`NTBW_F_EN] = en;
         setup_word[`NTBW_F_SIZE_HI:`NTBW_F_SIZE_LO] = size;
         setup_word[`NTBW_F_FETCH] = fetch;
         setup_word[`NTBW_F_TYPE_HI:`NTBW_F_TYPE_LO] = typ;
         setup_word[`NTBW_F_SPACE] = space;
      end
   endfunction

   ntbw_ahb_if u_bus
   (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .hsel(HSEL),
      .haddr(HADDR),
      .htrans(HTRANS),
      .hwrite(HWRITE),
      .hsize(HSIZE),
      .hready(HREADY),
      .rd_data(rd_nxt),
      .acc(acc),
      .acc_wr(acc_wr),
      .acc_addr(acc_addr),
      .hrdata_r(HRDATA),
      .hreadyout_r(HREADYOUT)
   );

   always @*
   begin
      wide = 1'b0;
      if (!space_r[0] && (type_r[0] == `NTBW_TYPE_ADDR64))
      begin
         wide = 1'b1;
      end
   end

   // Slices: window 0 low word, window 0 upper word, window 1 own word.
   assign msize[0] = size_r[0];
   assign msize[1] = size_r[0];
   assign msize[2] = size_r[1];
   assign mupper[0] = 1'b0;
   assign mupper[1] = 1'b1;
   assign mupper[2] = 1'b0;

   genvar k;
   generate
      for (k = 0; k < 3; k = k + 1)
      begin : g_mask
         ntbw_bar_mask u_mask
         (
            .size(msize[k]),
            .upper(mupper[k]),
            .wide(wide),
            .mask(mask[k])
         );
      end
   endgenerate

   // I/O space forces type to zero.
   always @*
   begin
      new_type0 = HWDATA[`NTBW_F_TYPE_HI:`NTBW_F_TYPE_LO];
      if (HWDATA[`NTBW_F_SPACE])
      begin
         new_type0 = 2'h0;
      end
   end
   // reserved codes of window 1 are not kept.
   assign new_type1 = `NTBW_TYPE_ADDR32;

   always @*
   begin
      bar0_rd = `NTBW_RST_WORD;
      if (en_r[0])
      begin
         bar0_rd = {bar0_r[31:4] & mask[0][31:4], fetch_r[0], type_r[0], space_r[0]};
      end
   end
   // window 1 carries the upper base bits when paired.
   // space bit and fetch bit reported.
   always @*
   begin
      bar1_rd = `NTBW_RST_WORD;
      if (wide)
      begin
         if (en_r[0])
         begin
            bar1_rd = bar1_r & mask[1];
         end
      end
      else if (en_r[1])
      begin
         bar1_rd = {bar1_r[31:4] & mask[2][31:4], fetch_r[1], type_r[1], space_r[1]};
      end
   end

   assign setup0_rd = setup_word(en_r[0], size_r[0], fetch_r[0], type_r[0], space_r[0]);
   // paired window 1 setup reads zero.
   always @*
   begin
      setup1_rd = `NTBW_RST_SETUP;
      if (!wide)
      begin
         setup1_rd = setup_word(en_r[1], size_r[1], fetch_r[1], type_r[1], space_r[1]);
      end
   end

   // upper halves of translation and base.
   // A narrow window keeps its upper halves at zero, so the datapath never sees stale bits.
   always @*
   begin
      xlat_hi = `NTBW_RST_WORD;
      base_hi = `NTBW_RST_WORD;
      if (wide)
      begin
         xlat_hi = xupper_r;
         base_hi = bar1_rd;
      end
   end

   // Unmapped offsets fall through to zero, which software sees as an absent register.
   always @*
   begin
      rd_nxt = `NTBW_RST_WORD;
      if (hit(acc_addr, `NTBW_OFS_W0_SETUP))
      begin
         rd_nxt = setup0_rd;
      end
      else if (hit(acc_addr, `NTBW_OFS_W1_SETUP))
      begin
         rd_nxt = setup1_rd;
      end
      else if (hit(acc_addr, `NTBW_OFS_W0_XBASE))
      begin
         rd_nxt = {xbase_r, 4'h0};
      end
      else if (hit(acc_addr, `NTBW_OFS_W0_XUPPER))
      begin
         rd_nxt = xupper_r;
      end
      else if (hit(acc_addr, `NTBW_OFS_W0_BAR))
      begin
         rd_nxt = bar0_rd;
      end
      else if (hit(acc_addr, `NTBW_OFS_W1_BAR))
      begin
         rd_nxt = bar1_rd;
      end
   end

   // setup fields kept across fundamental and hot reset.
   always @(posedge REF_CLK or posedge COLD_RST)
   begin
      if (COLD_RST)
      begin
         en_r[0] <= 1'b0;
         space_r[0] <= 1'b0;
         type_r[0] <= 2'h0;
         fetch_r[0] <= 1'b0;
         size_r[0] <= 6'h00;
         en_r[1] <= 1'b0;
         space_r[1] <= 1'b0;
         type_r[1] <= 2'h0;
         fetch_r[1] <= 1'b0;
         size_r[1] <= 6'h00;
         xbase_r <= `NTBW_RST_XBASE;
         xupper_r <= `NTBW_RST_WORD;
      end
      else if (acc_wr)
      begin
         if (hit(acc_addr, `NTBW_OFS_W0_SETUP))
         begin
            en_r[0] <= HWDATA[`NTBW_F_EN];
            space_r[0] <= HWDATA[`NTBW_F_SPACE];
            type_r[0] <= new_type0;
            fetch_r[0] <= HWDATA[`NTBW_F_FETCH];
            size_r[0] <= HWDATA[`NTBW_F_SIZE_HI:`NTBW_F_SIZE_LO];
         end
         if (hit(acc_addr, `NTBW_OFS_W1_SETUP) && !wide)
         begin
            en_r[1] <= HWDATA[`NTBW_F_EN];
            space_r[1] <= HWDATA[`NTBW_F_SPACE];
            type_r[1] <= new_type1;
            fetch_r[1] <= HWDATA[`NTBW_F_FETCH];
            size_r[1] <= HWDATA[`NTBW_F_SIZE_HI:`NTBW_F_SIZE_LO];
         end
         if (hit(acc_addr, `NTBW_OFS_W0_XBASE))
         begin
            xbase_r <= HWDATA[31:`NTBW_F_XBASE_LO];
         end
         if (hit(acc_addr, `NTBW_OFS_W0_XUPPER))
         begin
            xupper_r <= HWDATA;
         end
      end
   end

   // Only writable bits are kept, so a later size change cannot expose stale bits.
   always @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         bar0_r <= `NTBW_RST_WORD;
         bar1_r <= `NTBW_RST_WORD;
      end
      else if (acc_wr)
      begin
         if (hit(acc_addr, `NTBW_OFS_W0_BAR) && en_r[0])
         begin
            bar0_r <= HWDATA & mask[0];
         end
         if (hit(acc_addr, `NTBW_OFS_W1_BAR))
         begin
            if (wide && en_r[0])
            begin
               bar1_r <= HWDATA & mask[1];
            end
            else if (!wide && en_r[1])
            begin
               bar1_r <= HWDATA & mask[2];
            end
         end
      end
   end

   // Datapath-facing copies leave from flops one cycle after the fields.
   always @(posedge REF_CLK or posedge SYS_RST)
   begin
      if (SYS_RST)
      begin
         HRESP <= `NTBW_HRESP_OKAY;
         WIN0_ENABLE <= 1'b0;
         WIN0_WIDE <= 1'b0;
         WIN0_XLAT_BASE <= {2{`NTBW_RST_WORD}};
         WIN0_BASE <= {2{`NTBW_RST_WORD}};
         WIN1_ENABLE <= 1'b0;
         WIN1_BASE <= `NTBW_RST_WORD;
      end
      else
      begin
         HRESP <= `NTBW_HRESP_OKAY;
         WIN0_ENABLE <= en_r[0];
         WIN0_WIDE <= wide;
         // upper half joins only in 64-bit mode.
         WIN0_XLAT_BASE <= {xlat_hi, xbase_r, 4'h0};
         WIN0_BASE <= {base_hi, bar0_rd[31:4], 4'h0};
         // a paired window 1 never decodes on its own.
         WIN1_ENABLE <= en_r[1] && !wide;
         WIN1_BASE <= wide ? `NTBW_RST_WORD : {bar1_rd[31:4], 4'h0};
      end
   end
endmodule // ntbw_regs
`default_nettype wire

// *** sim/ntbw_regs_properties.sv ***
// Concurrent checks on the bus timing and window outputs of the bank.
// Assumes HREADY is the bank's own HREADYOUT, a single slave on the bus.
`timescale 1ns/1ns
`default_nettype none
module ntbw_props
(
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HREADY,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic [31:0] HRDATA,
   input wire logic WIN0_ENABLE,
   input wire logic WIN0_WIDE,
   input wire logic [63:0] WIN0_XLAT_BASE,
   input wire logic [63:0] WIN0_BASE,
   input wire logic WIN1_ENABLE,
   input wire logic [31:0] WIN1_BASE
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (SYS_RST);
   sequence taken;
      HSEL && HTRANS[1] && HREADY;
   endsequence
   sequence one_wait;
      !HREADYOUT ##1 HREADYOUT;
   endsequence
   a_one_wait_state:
      assert property (taken |=> one_wait) else $error("wait state count wrong");
   a_rdata_holds:
      assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA))
      else $error("read data moved while idle");
   a_resp_okay:
      assert property (HRESP == 1'b0) else $error("response not okay");
   a_pair_hides_w1:
      assert property (WIN0_WIDE |-> !WIN1_ENABLE && WIN1_BASE == 32'h0)
      else $error("window 1 visible while paired");
   a_w0_off_zero:
      assert property (!WIN0_ENABLE |-> WIN0_BASE == 64'h0) else $error("disabled base not zero");
   a_narrow_upper_zero:
      assert property (!WIN0_WIDE |-> WIN0_BASE[63:32] == 32'h0) else $error("narrow upper base");
   a_xlat_upper_zero:
      assert property (!WIN0_WIDE |-> WIN0_XLAT_BASE[63:32] == 32'h0)
      else $error("narrow upper translation");
   a_xlat_low_zero:
      assert property (WIN0_XLAT_BASE[3:0] == 4'h0) else $error("translation low bits set");
   a_w1_type_zero:
      assert property (WIN1_BASE[2:1] == 2'h0) else $error("window 1 type not zero");
endmodule // ntbw_props
bind ntbw_regs ntbw_props u_props (.*);
`default_nettype wire

// *** sim/ntbw_regs_test.sv ***
// Self-checking bench for the window setup register bank.
// Assumes the bank is the only AHB-Lite slave and answers with one wait state.
`timescale 1ns/1ns
`default_nettype none
module ntbw_regs_test;
   logic REF_CLK = 1'b0;
   logic SYS_RST = 1'b1;
   logic COLD_RST = 1'b1;
   logic HSEL = 1'b1;
   logic [31:0] HADDR = 32'h0;
   logic [1:0] HTRANS = 2'h0;
   logic HWRITE = 1'b0;
   logic [2:0] HSIZE = 3'h2;
   logic [31:0] HWDATA = 32'h0;
   wire HREADY;
   wire HREADYOUT, HRESP, WIN0_ENABLE, WIN0_WIDE, WIN1_ENABLE;
   wire [31:0] HRDATA, WIN1_BASE;
   wire [63:0] WIN0_XLAT_BASE, WIN0_BASE, target;
   int bad_count = 0;
   int checks_done = 0;
   assign HREADY = HREADYOUT;
   ntbw_regs u_dut (.*);
   ntbw_xlat_model u_xlat (.enable(WIN0_ENABLE), .xlat_base(WIN0_XLAT_BASE),
      .offset(32'h00000120), .target(target));
   initial
   begin
      forever #5 REF_CLK = ~REF_CLK;
   end
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits for an edge that samples ready high; a stuck bus ends the run.
   task automatic rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge REF_CLK);
         n++;
      end
      while (HREADYOUT !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         bad_count++;
         give_verdict();
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r);
      HTRANS <= 2'h2;
      HADDR <= {20'h0, a};
      HWRITE <= w;
      rdy();
      HTRANS <= 2'h0;
      HWDATA <= d;
      rdy();
      r = HRDATA;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk({32'h0, r}, {32'h0, e});
   endtask
   initial
   begin
      repeat (4) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      COLD_RST <= 1'b0;
      @(posedge REF_CLK);
      rc(12'h07C, 32'h0);
      rc(12'h080, 32'h0);
      rc(12'h084, 32'h0);
      rc(12'h010, 32'h0);
      $display("test 1 reset values done");
      wr(12'h07C, 32'hFFFFFFFF);
      rc(12'h07C, 32'h800003F9);
      wr(12'h080, 32'hFFFFFFFF);
      rc(12'h080, 32'hFFFFFFF0);
      wr(12'h084, 32'h8000000F);
      rc(12'h084, 32'h80000009);
      rc(12'h014, 32'h00000009);
      wr(12'h084, 32'h8000000E);
      rc(12'h084, 32'h80000008);
      rc(12'h014, 32'h00000008);
      chk({63'h0, WIN1_ENABLE}, 64'h1);
      chk({63'h0, WIN0_WIDE}, 64'h0);
      $display("test 2 field codes done");
      wr(12'h07C, 32'h000000C0);
      wr(12'h010, 32'hFFFFFFFF);
      rc(12'h010, 32'h0);
      wr(12'h07C, 32'h800000C0);
      wr(12'h010, 32'hFFFFFFFF);
      rc(12'h010, 32'hFFFFF000);
      wr(12'h07C, 32'h80000280);
      wr(12'h010, 32'hFFFFFFFF);
      rc(12'h010, 32'h0);
      $display("test 3 window 0 enable and size done");
      wr(12'h07C, 32'h80000004);
      wr(12'h080, 32'hABCDE00F);
      wr(12'h088, 32'h12345678);
      wr(12'h084, 32'h8000000F);
      rc(12'h084, 32'h0);
      wr(12'h010, 32'h00001000);
      wr(12'h014, 32'hCAFEF00D);
      rc(12'h010, 32'h00001004);
      rc(12'h014, 32'hCAFEF00D);
      chk(WIN0_XLAT_BASE, 64'h12345678ABCDE000);
      chk(WIN0_BASE, 64'hCAFEF00D00001000);
      chk(target, 64'h12345678ABCDE120);
      chk({63'h0, WIN0_WIDE}, 64'h1);
      chk({63'h0, WIN1_ENABLE}, 64'h0);
      chk({32'h0, WIN1_BASE}, 64'h0);
      HSIZE <= 3'h0;
      wr(12'h088, 32'h0);
      HSIZE <= 3'h2;
      rc(12'h088, 32'h12345678);
      $display("test 4 paired windows done");
      // A fundamental or hot reset must leave the setup state in place.
      SYS_RST <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      @(posedge REF_CLK);
      rc(12'h07C, 32'h80000004);
      rc(12'h080, 32'hABCDE000);
      rc(12'h088, 32'h12345678);
      rc(12'h100, 32'h0);
      chk(WIN0_XLAT_BASE, 64'h12345678ABCDE000);
      $display("test 5 sticky fields done");
      give_verdict();
   end
endmodule // ntbw_regs_test
`default_nettype wire

// *** sim/ntbw_xlat_model.sv ***
// Far-side model: forms the address that a hit through window 0 is sent to.
// Assumes the window outputs of the register bank, sampled when settled.
`timescale 1ns/1ns
`default_nettype none
module ntbw_xlat_model
(
   input wire logic enable,
   input wire logic [63:0] xlat_base,
   input wire logic [31:0] offset,
   output logic [63:0] target
);
   assign target = enable ? xlat_base + {32'h0, offset} : 64'h0;
endmodule // ntbw_xlat_model
`default_nettype wire
